// ### core/ckl_pkg.sv
// Shared constants and types of the key lifecycle controller
package ckl_pkg;

  // Widths
  localparam int LCS_W = 4;
  localparam int WORD_W = 32;
  localparam int KEY_WORDS = 4;
  localparam int KEY_W = 128;
  localparam int ADDR_W = 32;
  localparam int REQ_LEN_W = 32;
  localparam int DMA_LEN_W = 16;

  // Lifecycle encodings; reset reports secure
  localparam logic [3:0] LCS_DEBUG = 4'h0;
  localparam logic [3:0] LCS_SECURE = 4'h2;
  localparam logic [3:0] LCS_RESET = LCS_SECURE;
  localparam logic LCS_VALID_RESET = 1'h0;

  // Reset values of the always-on content and controls
  localparam logic [127:0] ROOT_KEY_RESET = 128'h0;
  localparam logic [3:0] WORD_WRITTEN_RESET = 4'h0;
  localparam logic LOCK_RESET = 1'h0;
  localparam logic [127:0] ZERO_KEY = 128'h0;

  // Hard-wired design key; value is arbitrary
  localparam logic [127:0] DESIGN_KEY = 128'h5a3c_96e1_0f7b_24d8_c3a5_1e69_b702_4fd8;

  // Largest single transfer, in bytes
  localparam logic [15:0] DMA_MAX_LEN = 16'hffff;

  // Key source codes
  typedef enum logic [1:0] {
    KSEL_ROOT = 2'b00,
    KSEL_DESIGN = 2'b01,
    KSEL_SESSION = 2'b10
  } ckl_keysel_e;
  localparam ckl_keysel_e KSEL_RESET = KSEL_ROOT;

  // Transfer splitter states
  typedef enum logic {
    DMA_IDLE = 1'b0,
    DMA_BURST = 1'b1
  } ckl_dma_state_e;

  // Write of one root key word
  typedef struct packed {
    logic en;
    logic [1:0] idx;
    logic [31:0] data;
  } ckl_rootkey_wr_s;

  // Software transfer request
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] len;
  } ckl_dma_req_s;

  // One bus transfer of bounded size
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [15:0] len;
  } ckl_dma_xfer_s;

endpackage

// ### core/ckl_dma_limit.sv
// Splits a transfer request into bus transfers of bounded size
`timescale 1ns/1ns
module ckl_dma_limit
  import ckl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request side
  input wire ckl_dma_req_s req,
  input wire logic enable,
  output logic reqReady,
  // Bus side
  output ckl_dma_xfer_s xfer,
  input wire logic xferReady
);

  ckl_dma_state_e state;
  logic [31:0] remain;
  logic [31:0] nextAddr;
  logic [15:0] chunk;

  // Size of the next piece, never above the limit
  always_comb begin
    if (remain > {16'h0, DMA_MAX_LEN}) begin
      chunk = DMA_MAX_LEN;
    end else begin
      chunk = remain[15:0];
    end
  end

  // Request intake and piece issue
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= DMA_IDLE;
      reqReady <= 1'b1;
      remain <= 32'h0;
      nextAddr <= 32'h0;
      xfer <= '0;
    end else begin
      unique case (state)
        DMA_IDLE: begin
          if (req.valid && reqReady && enable) begin
            remain <= req.len;
            nextAddr <= req.addr;
            reqReady <= 1'b0;
            state <= DMA_BURST;
          end
        end
        DMA_BURST: begin
          if (!xfer.valid || xferReady) begin
            if (remain != 32'h0) begin
              // R16 - bounded piece size
              xfer.valid <= 1'b1;
              xfer.len <= chunk;
              xfer.addr <= nextAddr;
              remain <= remain - {16'h0, chunk};
              nextAddr <= nextAddr + {16'h0, chunk};
            end else begin
              xfer.valid <= 1'b0;
              reqReady <= 1'b1;
              state <= DMA_IDLE;
            end
          end
        end
      endcase
    end
  end

  a_xfer_len_bound: assert property (  // R16
    @(posedge clk_sys) disable iff (rst) xfer.valid |-> (xfer.len <= DMA_MAX_LEN && xfer.len != 16'h0))
    else $error("transfer length out of range");

  a_xfer_held: assert property (
    @(posedge clk_sys) disable iff (rst) xfer.valid && !xferReady |=> xfer.valid && $stable(xfer))
    else $error("transfer changed before acceptance");

endmodule

// ### core/ckl_key_lifecycle_ctrl.sv
// Key storage, lifecycle and key routing with bounded transfer master
// Overview of operation
// R1 - Keep lifecycle, lock and root key retained
// R2 - Any reset clears all retained content
// R3 - Debug or secure write makes lifecycle valid
// R4 - Reset reports secure lifecycle, flag invalid
// R5 - Secure lifecycle: each key word once
// R6 - Debug lifecycle: key words freely rewritable
// R7 - Software picks design, root or session key
// R8 - Select codes: root 0, design 1, session 2
// R9 - Design key fixed, never visible to software
// R10 - Lock write forbids design key until reset
// R11 - Lock cannot be cleared by software
// R12 - Locked design key selected gives zero key
// R13 - Store 128-bit root key until reset
// R14 - Root key words never read back
// R15 - Word zero reads retention status one
// R16 - Transfers limited to 65535 bytes each
// R17 - Software stages unreachable data into SRAM
// R18 - Enabled subsystem keeps requesting activity
// R19 - Illegal lifecycle write leaves flag invalid
`timescale 1ns/1ns
module ckl_key_lifecycle_ctrl
  import ckl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Subsystem enable and activity request
  input wire logic enable,
  output logic activityReq,
  // Lifecycle control
  input wire logic lcsWrEn,
  input wire logic [3:0] lcsWrData,
  output logic [3:0] lifecycleState,
  output logic lifecycleValid,
  // Root key words
  input wire ckl_rootkey_wr_s rootKeyWr,
  output logic rootKeyRetained,
  // Key source select and design key lock
  input wire logic keySelWrEn,
  input wire logic [1:0] keySelWrData,
  output ckl_keysel_e keySelect,
  input wire logic lockWrEn,
  output logic designKeyLocked,
  // Key to the cipher engine
  input wire logic [127:0] sessionKey,
  output logic [127:0] aesKey,
  // Transfer master
  input wire ckl_dma_req_s dmaReq,
  output logic dmaReqReady,
  output ckl_dma_xfer_s dmaXfer,
  input wire logic dmaXferReady
);

  // Legal lifecycle codes
  function automatic logic lcsIsLegal(input logic [3:0] code);
    lcsIsLegal = (code == LCS_DEBUG) || (code == LCS_SECURE);
  endfunction

  // Legal key select codes
  function automatic logic kselIsLegal(input logic [1:0] code);
    kselIsLegal = (code == KSEL_ROOT) || (code == KSEL_DESIGN) || (code == KSEL_SESSION);
  endfunction

  logic [127:0] rootKey;
  logic [3:0] wordWritten;
  logic [3:0] wordAccept;
  logic debugMode;
  logic [127:0] next_aesKey;

  assign debugMode = lifecycleValid && (lifecycleState == LCS_DEBUG);

  // Lifecycle is set once; until then it reads secure and invalid
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // R2 - clear lifecycle
      // R4 - secure and invalid
      lifecycleState <= LCS_RESET;
      lifecycleValid <= LCS_VALID_RESET;
    end else if (lcsWrEn && !lifecycleValid) begin
      // R3 - legal code validates
      // R19 - illegal code ignored
      if (lcsIsLegal(lcsWrData)) begin
        lifecycleState <= lcsWrData;
        lifecycleValid <= 1'b1;
      end
    end
  end

  // Per-word write permission and storage
  generate
    for (genvar w = 0; w < KEY_WORDS; w++) begin : gWord
      // R5 - once per reset unless debug
      // R6 - debug allows rewrites
      assign wordAccept[w] = rootKeyWr.en && (rootKeyWr.idx == 2'(w)) &&
                             (debugMode || !wordWritten[w]);

      // R1 - retained word storage
      // R13 - hold until reset
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          rootKey[w*WORD_W +: WORD_W] <= ROOT_KEY_RESET[w*WORD_W +: WORD_W];
          wordWritten[w] <= WORD_WRITTEN_RESET[w];
        end else if (wordAccept[w]) begin
          rootKey[w*WORD_W +: WORD_W] <= rootKeyWr.data;
          wordWritten[w] <= 1'b1;
        end
      end
    end
  endgenerate

  // Retention status once all four words hold a value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rootKeyRetained <= 1'b0;
    end else if (&wordWritten) begin
      // R15 - status reads one
      // R14 - only status visible
      rootKeyRetained <= 1'b1;
    end
  end

  // Sticky design key lock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      designKeyLocked <= LOCK_RESET;
    end else if (lockWrEn) begin
      // R10 - lock until reset
      // R11 - no software clear
      designKeyLocked <= 1'b1;
    end
  end

  // Key source select; unused code is dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      keySelect <= KSEL_RESET;
    end else if (keySelWrEn && kselIsLegal(keySelWrData)) begin
      // R8 - fixed select codes
      keySelect <= ckl_keysel_e'(keySelWrData);
    end
  end

  // Key routing toward the cipher engine
  always_comb begin
    unique case (keySelect)
      // R7 - three key sources
      KSEL_ROOT: next_aesKey = rootKey;
      // R9 - fixed key only on engine path
      // R12 - zero key when locked
      KSEL_DESIGN: next_aesKey = designKeyLocked ? ZERO_KEY : DESIGN_KEY;
      KSEL_SESSION: next_aesKey = sessionKey;
      default: next_aesKey = ZERO_KEY;
    endcase
  end

  // Registered engine key
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aesKey <= ZERO_KEY;
    end else begin
      aesKey <= next_aesKey;
    end
  end

  // Activity request follows the enable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      activityReq <= 1'b0;
    end else begin
      // R18 - stay active while enabled
      activityReq <= enable;
    end
  end

  // Bounded transfer master; data is expected in reachable memory
  ckl_dma_limit uDma (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(dmaReq),
    .enable(enable),
    .reqReady(dmaReqReady),
    .xfer(dmaXfer),
    .xferReady(dmaXferReady)
  );

  a_reset_secure_invalid: assert property (  // R4
    @(posedge clk_sys) disable iff (rst) !lifecycleValid |-> lifecycleState == LCS_SECURE)
    else $error("unconfigured lifecycle not reported as secure");

  a_lcs_validates: assert property (  // R3
    @(posedge clk_sys) disable iff (rst)
    lcsWrEn && !lifecycleValid && lcsIsLegal(lcsWrData)
    |=> lifecycleValid && lifecycleState == $past(lcsWrData))
    else $error("legal lifecycle write did not validate");

  a_lcs_bad_ignored: assert property (  // R19
    @(posedge clk_sys) disable iff (rst)
    lcsWrEn && !lifecycleValid && !lcsIsLegal(lcsWrData) |=> !lifecycleValid)
    else $error("illegal lifecycle write validated");

  a_secure_write_once: assert property (  // R5
    @(posedge clk_sys) disable iff (rst)
    rootKeyWr.en && !debugMode && wordWritten[rootKeyWr.idx] |=> $stable(rootKey))
    else $error("secure root key word rewritten");

  a_debug_rewrite: assert property (  // R6
    @(posedge clk_sys) disable iff (rst)
    rootKeyWr.en && debugMode
    |=> rootKey[$past(rootKeyWr.idx)*WORD_W +: WORD_W] == $past(rootKeyWr.data))
    else $error("debug root key write not stored");

  a_lock_sticky: assert property (  // R11
    @(posedge clk_sys) disable iff (rst) designKeyLocked |=> designKeyLocked)
    else $error("design key lock cleared");

  a_locked_zero_key: assert property (  // R12
    @(posedge clk_sys) disable iff (rst)
    designKeyLocked && keySelect == KSEL_DESIGN |=> aesKey == ZERO_KEY)
    else $error("locked design key reached engine");

  a_root_key_routed: assert property (  // R7
    @(posedge clk_sys) disable iff (rst)
    keySelect == KSEL_ROOT |=> aesKey == $past(rootKey))
    else $error("root key not routed");

  a_retained_status: assert property (  // R15
    @(posedge clk_sys) disable iff (rst) $rose(&wordWritten) |=> rootKeyRetained)
    else $error("retention status not raised");

  a_activity_enabled: assert property (  // R18
    @(posedge clk_sys) disable iff (rst) enable |=> activityReq)
    else $error("activity request dropped while enabled");

  a_activity_disabled: assert property (  // R18
    @(posedge clk_sys) disable iff (rst) !enable |=> !activityReq)
    else $error("activity request held while disabled");

  // Lifecycle stays fixed once configured
  a_lcs_frozen: assert property (  // R3
    @(posedge clk_sys) disable iff (rst) lifecycleValid |=> lifecycleValid && $stable(lifecycleState))
    else $error("lifecycle changed after validation");

  a_lcs_legal_code: assert property (  // R3
    @(posedge clk_sys) disable iff (rst) lifecycleValid |-> lcsIsLegal(lifecycleState))
    else $error("valid lifecycle holds an illegal code");

  // Root key storage and retention status
  a_written_sticky: assert property (  // R5
    @(posedge clk_sys) disable iff (rst)
    |wordWritten |=> (wordWritten & $past(wordWritten)) == $past(wordWritten))
    else $error("root key written flag cleared");

  a_root_key_held: assert property (  // R13
    @(posedge clk_sys) disable iff (rst) !rootKeyWr.en |=> $stable(rootKey))
    else $error("root key changed without a write");

  a_retained_sticky: assert property (  // R15
    @(posedge clk_sys) disable iff (rst) rootKeyRetained |=> rootKeyRetained)
    else $error("retention status dropped");

  a_retained_all_words: assert property (  // R15
    @(posedge clk_sys) disable iff (rst) rootKeyRetained |-> &wordWritten)
    else $error("retention status before all words written");

  // Key select, lock and routing
  a_lock_on_write: assert property (  // R10
    @(posedge clk_sys) disable iff (rst) lockWrEn |=> designKeyLocked)
    else $error("lock write did not lock design key");

  a_sel_legal_taken: assert property (  // R8
    @(posedge clk_sys) disable iff (rst)
    keySelWrEn && kselIsLegal(keySelWrData) |=> keySelect == $past(keySelWrData))
    else $error("legal key select code not taken");

  a_sel_illegal_kept: assert property (  // R8
    @(posedge clk_sys) disable iff (rst)
    keySelWrEn && !kselIsLegal(keySelWrData) |=> $stable(keySelect))
    else $error("unused key select code taken");

  a_sel_in_range: assert property (  // R8
    @(posedge clk_sys) disable iff (rst) keySelect != 2'b11)
    else $error("key select holds unused code");

  a_design_key_routed: assert property (  // R9
    @(posedge clk_sys) disable iff (rst)
    !designKeyLocked && keySelect == KSEL_DESIGN |=> aesKey == DESIGN_KEY)
    else $error("unlocked design key not routed");

  a_session_routed: assert property (  // R7
    @(posedge clk_sys) disable iff (rst) keySelect == KSEL_SESSION |=> aesKey == $past(sessionKey))
    else $error("session key not routed");

  // Transfer master busy while a piece is out
  a_busy_while_xfer: assert property (  // R16
    @(posedge clk_sys) disable iff (rst) dmaXfer.valid |-> !dmaReqReady)
    else $error("request taken while a transfer is pending");

endmodule

// ### bench/ckl_key_lifecycle_ctrl_test.sv
// Self-checking testbench of the key lifecycle controller
`timescale 1ns/1ns
module ckl_key_lifecycle_ctrl_test
  import ckl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic enable = 1'b0;
  logic lcsWrEn = 1'b0;
  logic [3:0] lcsWrData = 4'h0;
  ckl_rootkey_wr_s rootKeyWr = '0;
  logic keySelWrEn = 1'b0;
  logic [1:0] keySelWrData = 2'h0;
  logic lockWrEn = 1'b0;
  logic [127:0] sessionKey = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  ckl_dma_req_s dmaReq = '0;
  logic dmaXferReady = 1'b0;
  logic activityReq, lifecycleValid, rootKeyRetained, designKeyLocked, dmaReqReady;
  logic [3:0] lifecycleState;
  ckl_keysel_e keySelect;
  logic [127:0] aesKey;
  ckl_dma_xfer_s dmaXfer;
  int mismatches = 0;
  int checked = 0;
  logic [127:0] rootVal = 128'h1111_2222_3333_4444_5555_6666_7777_8888;

  // Design under test
  ckl_key_lifecycle_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .enable(enable),
    .activityReq(activityReq), .lcsWrEn(lcsWrEn), .lcsWrData(lcsWrData),
    .lifecycleState(lifecycleState), .lifecycleValid(lifecycleValid), .rootKeyWr(rootKeyWr),
    .rootKeyRetained(rootKeyRetained), .keySelWrEn(keySelWrEn), .keySelWrData(keySelWrData),
    .keySelect(keySelect), .lockWrEn(lockWrEn), .designKeyLocked(designKeyLocked),
    .sessionKey(sessionKey), .aesKey(aesKey), .dmaReq(dmaReq), .dmaReqReady(dmaReqReady),
    .dmaXfer(dmaXfer), .dmaXferReady(dmaXferReady));

  // Clock, 10 ns period
  always #5 clk_sys = ~clk_sys;

  // Compare and count
  task chk(input logic [127:0] seen, input logic [127:0] exp, input string name);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Reset held for 4 cycles
  task do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
  endtask

  // One write strobe: 0 lifecycle, 1 key word, 2 select, 3 lock
  task wr(input int kind, input logic [1:0] idx, input logic [31:0] d);
    @(posedge clk_sys);
    case (kind)
      0: begin
        lcsWrEn <= 1'b1;
        lcsWrData <= d[3:0];
      end
      1: rootKeyWr <= '{1'b1, idx, d};
      2: begin
        keySelWrEn <= 1'b1;
        keySelWrData <= d[1:0];
      end
      default: lockWrEn <= 1'b1;
    endcase
    @(posedge clk_sys);
    lcsWrEn <= 1'b0;
    rootKeyWr.en <= 1'b0;
    keySelWrEn <= 1'b0;
    lockWrEn <= 1'b0;
    #1;
  endtask

  // Wait for one bus transfer, stall, then accept it
  task take_xfer(input logic [31:0] addr, input logic [15:0] len);
    int n;
    n = 0;
    while (dmaXfer.valid !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(dmaXfer.valid, 1, "xfer valid");
    chk(dmaXfer.addr, addr, "xfer addr");
    chk(dmaXfer.len, len, "xfer len");
    @(posedge clk_sys);
    dmaReq.valid <= 1'b0;
    @(posedge clk_sys);
    dmaXferReady <= 1'b1;
    @(posedge clk_sys);
    dmaXferReady <= 1'b0;
    #1;
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end

  // Main sequence
  initial begin
    do_reset();
    chk(lifecycleState, LCS_SECURE, "lcs reset");
    chk(lifecycleValid, 0, "valid reset");
    chk(rootKeyRetained, 0, "retained reset");
    chk(aesKey, 0, "aes reset");
    chk(dmaReqReady, 1, "dma ready reset");
    chk(activityReq, 0, "activity reset");
    wr(0, 0, 32'h5);
    chk(lifecycleValid, 0, "valid illegal");
    wr(0, 0, LCS_SECURE);
    chk(lifecycleValid, 1, "valid secure");
    chk(lifecycleState, LCS_SECURE, "lcs secure");
    wr(0, 0, LCS_DEBUG);
    chk(lifecycleState, LCS_SECURE, "lcs second write");
    for (int i = 0; i < 4; i++) begin
      wr(1, i[1:0], rootVal[32*i +: 32]);
    end
    repeat (2) @(posedge clk_sys);
    #1;
    chk(rootKeyRetained, 1, "retained");
    chk(aesKey, rootVal, "aes root");
    wr(1, 2'h1, 32'hdead_beef);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(aesKey, rootVal, "aes write once");
    // Design, session and unused select codes, then the lock
    wr(2, 0, KSEL_DESIGN);
    @(posedge clk_sys);
    #1;
    chk(aesKey, DESIGN_KEY, "aes design");
    chk(keySelect, KSEL_DESIGN, "sel design");
    wr(2, 0, KSEL_SESSION);
    @(posedge clk_sys);
    #1;
    chk(aesKey, sessionKey, "aes session");
    wr(2, 0, 32'h3);
    chk(keySelect, KSEL_SESSION, "sel code 3");
    wr(3, 0, 0);
    chk(designKeyLocked, 1, "locked");
    wr(2, 0, KSEL_DESIGN);
    @(posedge clk_sys);
    #1;
    chk(aesKey, ZERO_KEY, "aes locked");
    chk(designKeyLocked, 1, "lock holds");
    // Enable and a transfer above the size limit
    @(posedge clk_sys);
    enable <= 1'b1;
    @(posedge clk_sys);
    dmaReq <= '{1'b1, 32'h1000, 32'd70000};
    #1;
    chk(activityReq, 1, "activity");
    take_xfer(32'h1000, DMA_MAX_LEN);
    take_xfer(32'h1000 + 32'd65535, 16'd4465);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(dmaXfer.valid, 0, "xfer done");
    chk(dmaReqReady, 1, "dma ready back");
    // Second reset, then debug lifecycle
    @(posedge clk_sys);
    do_reset();
    chk(designKeyLocked, 0, "lock cleared");
    chk(lifecycleValid, 0, "valid cleared");
    chk(rootKeyRetained, 0, "retained cleared");
    wr(0, 0, LCS_DEBUG);
    chk(lifecycleState, LCS_DEBUG, "lcs debug");
    wr(1, 2'h0, 32'haaaa_5555);
    wr(1, 2'h0, 32'h1234_5678);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(aesKey, 128'h1234_5678, "aes debug rewrite");
    wr(2, 0, KSEL_DESIGN);
    @(posedge clk_sys);
    #1;
    chk(aesKey, DESIGN_KEY, "aes design after reset");
    @(posedge clk_sys);
    enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(activityReq, 0, "activity off");
    finish_test();
  end
endmodule
